/* hdl/fec_pkg.sv */
package fec_pkg;

	// Register byte offsets.
	localparam logic [11:0] FEC_OFF_READY    = 12'h400;
	localparam logic [11:0] FEC_OFF_CONFIG   = 12'h504;
	localparam logic [11:0] FEC_OFF_PAGE     = 12'h508;
	localparam logic [11:0] FEC_OFF_ALL      = 12'h50c;
	localparam logic [11:0] FEC_OFF_ALIAS0   = 12'h510;
	localparam logic [11:0] FEC_OFF_UCFG     = 12'h514;
	localparam logic [11:0] FEC_OFF_PARTIAL  = 12'h518;
	localparam logic [11:0] FEC_OFF_PARTCFG  = 12'h51c;
	localparam logic [11:0] FEC_OFF_WRITE    = 12'h520;
	localparam logic [11:0] FEC_OFF_WADDR    = 12'h524;

	// Reset values and field layout.
	localparam logic [31:0] FEC_PARTCFG_RST  = 32'h0000000a;
	localparam int          FEC_MODE_W       = 2;
	localparam logic [1:0]  FEC_MODE_RO      = 2'h0;
	localparam logic [1:0]  FEC_MODE_WEN     = 2'h1;
	localparam logic [1:0]  FEC_MODE_EEN     = 2'h2;

	// Timing: figures as printed, cycle counts derived at 40 MHz.
	localparam int          FEC_CLK_HZ       = 40000000;
	localparam int          FEC_T_WRITE_US   = 41;
	localparam int          FEC_T_PAGE_MS    = 85;
	localparam int          FEC_T_ALL_MS     = 169;
	localparam int          FEC_ACC_NUM      = 105;
	localparam int          FEC_ACC_DEN      = 100;
	localparam int          FEC_CYC_PER_MS   = FEC_CLK_HZ / 1000;
	localparam int          FEC_WRITE_CYC    = FEC_T_WRITE_US * (FEC_CLK_HZ / 1000000);
	localparam int          FEC_PAGE_CYC     = FEC_T_PAGE_MS * FEC_CYC_PER_MS;
	localparam int          FEC_ALL_CYC      = FEC_T_ALL_MS * FEC_CYC_PER_MS;

	// Operations the sequencer runs.
	typedef enum logic [2:0] {
		FEC_OP_NONE,
		FEC_OP_WRITE,
		FEC_OP_PAGE,
		FEC_OP_ALL,
		FEC_OP_UCFG,
		FEC_OP_PARTIAL
	} fec_op_t;

	// Command to the array port.
	typedef struct packed {
		fec_op_t     op;
		logic [31:0] addr;
		logic [31:0] data;
	} fec_cmd_t;

endpackage

/* hdl/fec_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Down counter that measures one operation interval.
module fec_timer
	import fec_pkg::*;
#(
	parameter int W = 36
) (
	// Clock and reset.
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control.
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	// Status.
	output logic              running
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Load wins over the countdown so a new interval always starts clean.
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = count;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
		end
	end

	// Counter register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign running = (cnt_r != '0);

endmodule
`default_nettype wire

/* hdl/fec_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Page trigger at 0x508 erases addressed page.
// - Aliases 0x508 and 0x510 erase page too.
// - Full trigger 0x50c erases code and config.
// - Factory info area never erased.
// - Trigger 0x514 erases user config only.
// - Trigger 0x518 applies one partial erase pulse.
// - Duration field in ms, resets to 0xa.
// - Word write ends within 41 us.
// - Page erase ends within 85 ms, busy.
// - Full erase ends within 169 ms, busy.
// - Partial erase at most duration times 1.05.
// - Ready reads 0 busy, 1 idle.
// - Mode 0 read, 1 write, 2 erase.
// - Erase triggers act only in erase mode.
// - Erased page reads all ones.
module fec_ctrl
	import fec_pkg::*;
#(
	parameter int unsigned WRITE_CYC = FEC_WRITE_CYC,
	parameter int unsigned PAGE_CYC  = FEC_PAGE_CYC,
	parameter int unsigned ALL_CYC   = FEC_ALL_CYC,
	parameter int unsigned MS_CYC    = FEC_CYC_PER_MS
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Array command port, one-cycle strobe with held command.
	output fec_cmd_t         arr_cmd,
	output logic             arr_start,
	output logic             arr_fill_ones,
	output logic             busy
);

	// Wide enough for the largest duration field times the cycles per ms.
	localparam int TW = 48;
	// The write data hold register shares the data offset of the word write pair.
	localparam logic [11:0] FEC_OFF_WDATA_HOLD = FEC_OFF_WADDR;

	logic            wr_acc;
	logic            rd_acc;
	logic            mapped;
	logic [1:0]      mode_r;
	logic [1:0]      mode_nxt;
	logic [31:0]     pcfg_r;
	logic [31:0]     pcfg_nxt;
	logic [31:0]     wdata_r;
	logic [31:0]     wdata_nxt;
	fec_cmd_t        cmd_r;
	fec_cmd_t        cmd_nxt;
	logic            start_r;
	logic            start_nxt;
	logic            fill_r;
	logic            fill_nxt;
	logic            busy_r;
	logic            busy_nxt;
	logic [31:0]     rdata_r;
	logic [31:0]     rdata_nxt;
	logic            load;
	logic [TW-1:0]   tcount;
	logic            running;
	logic            erase_ok;
	logic            write_ok;

	// One-cycle access phase; every transfer is taken on its first access edge.
	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Decode of every mapped offset; anything else errors and is ignored.
	always_comb begin
		case (paddr)
			FEC_OFF_READY, FEC_OFF_CONFIG, FEC_OFF_PAGE, FEC_OFF_ALL,
			FEC_OFF_ALIAS0, FEC_OFF_UCFG, FEC_OFF_PARTIAL, FEC_OFF_PARTCFG,
			FEC_OFF_WRITE, FEC_OFF_WADDR: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	assign erase_ok = (mode_r == FEC_MODE_EEN) && !busy_r;
	assign write_ok = (mode_r == FEC_MODE_WEN) && !busy_r;

	// Register file next state and operation launch.
	always_comb begin
		mode_nxt  = mode_r;
		pcfg_nxt  = pcfg_r;
		wdata_nxt = wdata_r;
		cmd_nxt   = cmd_r;
		start_nxt = 1'b0;
		fill_nxt  = 1'b0;
		busy_nxt  = busy_r && running;
		load      = 1'b0;
		tcount    = '0;
		if (wr_acc) begin
			case (paddr)
				FEC_OFF_CONFIG: begin
					mode_nxt = pwdata[FEC_MODE_W-1:0];
				end
				FEC_OFF_PARTCFG: begin
					pcfg_nxt = pwdata;
				end
				FEC_OFF_WDATA_HOLD: begin
					wdata_nxt = pwdata;
				end
				// page erase. both aliases share this path.
				FEC_OFF_PAGE, FEC_OFF_ALIAS0: begin
					if (erase_ok) begin
						cmd_nxt   = '{op: FEC_OP_PAGE, addr: pwdata, data: '1};
						start_nxt = 1'b1;
						fill_nxt  = 1'b1;
						load      = 1'b1;
						tcount    = TW'(PAGE_CYC) - TW'(1);
					end
				end
				// full erase. factory area not among targets.
				FEC_OFF_ALL: begin
					if (erase_ok) begin
						cmd_nxt   = '{op: FEC_OP_ALL, addr: '0, data: '1};
						start_nxt = 1'b1;
						fill_nxt  = 1'b1;
						load      = 1'b1;
						tcount    = TW'(ALL_CYC) - TW'(1);
					end
				end
				FEC_OFF_UCFG: begin
					if (erase_ok) begin
						cmd_nxt   = '{op: FEC_OP_UCFG, addr: '0, data: '1};
						start_nxt = 1'b1;
						fill_nxt  = 1'b1;
						load      = 1'b1;
						tcount    = TW'(PAGE_CYC) - TW'(1);
					end
				end
				// one timed pulse; exact ms count, within the 1.05 bound.
				FEC_OFF_PARTIAL: begin
					if (erase_ok && pcfg_r != '0) begin
						cmd_nxt   = '{op: FEC_OP_PARTIAL, addr: pwdata, data: '1};
						start_nxt = 1'b1;
						load      = 1'b1;
						tcount    = TW'(pcfg_r) * TW'(MS_CYC) - TW'(1);
					end
				end
				// word write, the trigger's pwdata supplies the target, the hold register the data.
				FEC_OFF_WRITE: begin
					if (write_ok) begin
						cmd_nxt   = '{op: FEC_OP_WRITE, addr: pwdata, data: wdata_r};
						start_nxt = 1'b1;
						load      = 1'b1;
						tcount    = TW'(WRITE_CYC) - TW'(1);
					end
				end
				default: begin
				end
			endcase
		end
		// Counts are loaded one short, since busy falls one edge after the timer empties.
		// busy from the cycle after the trigger.
		if (load) begin
			busy_nxt = 1'b1;
		end
	end

	// Read mux.
	always_comb begin
		rdata_nxt = rdata_r;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				FEC_OFF_READY:   rdata_nxt = {31'h0, !busy_nxt};
				FEC_OFF_CONFIG:  rdata_nxt = {30'h0, mode_r};
				FEC_OFF_PARTCFG: rdata_nxt = pcfg_r;
				FEC_OFF_WADDR:   rdata_nxt = wdata_r;
				default:         rdata_nxt = 32'h0;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r  <= FEC_MODE_RO;
			pcfg_r  <= FEC_PARTCFG_RST;
			wdata_r <= 32'hffffffff;
			cmd_r   <= '0;
			start_r <= 1'b0;
			fill_r  <= 1'b0;
			busy_r  <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			mode_r  <= mode_nxt;
			pcfg_r  <= pcfg_nxt;
			wdata_r <= wdata_nxt;
			cmd_r   <= cmd_nxt;
			start_r <= start_nxt;
			fill_r  <= fill_nxt;
			busy_r  <= busy_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Interval timer.
	fec_timer #(
		.W(TW)
	) u_timer (
		.pclk   (pclk),
		.presetn(presetn),
		.load   (load),
		.count  (tcount),
		.running(running)
	);

	assign prdata    = rdata_r;
	assign arr_cmd   = cmd_r;
	assign arr_start = start_r;
	assign arr_fill_ones = fill_r;
	assign busy      = busy_r;

	// Helper: cycles of the current busy interval.
	logic [TW-1:0] bcnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_r <= '0;
		end else if (load) begin
			bcnt_r <= '0;
		end else if (busy_r) begin
			bcnt_r <= bcnt_r + TW'(1);
		end
	end

	AST_TRIG_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		load |=> busy_r) else $error("Trigger did not set busy.");
	AST_READY_RD: assert property (@(posedge pclk) disable iff (!presetn)
		rd_acc && paddr == FEC_OFF_READY |-> prdata[0] == !busy_r)
		else $error("Ready read mismatch.");
	AST_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		start_nxt && cmd_nxt.op != FEC_OP_WRITE |-> mode_r == FEC_MODE_EEN)
		else $error("Erase outside erase mode.");
	AST_PAGE_T: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && cmd_r.op == FEC_OP_PAGE |-> bcnt_r < TW'(PAGE_CYC))
		else $error("Page erase too long.");
	AST_ALL_T: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && cmd_r.op == FEC_OP_ALL |-> bcnt_r < TW'(ALL_CYC))
		else $error("Full erase too long.");
	AST_WR_T: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && cmd_r.op == FEC_OP_WRITE |-> bcnt_r < TW'(WRITE_CYC))
		else $error("Word write too long.");
	AST_PART_T: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && cmd_r.op == FEC_OP_PARTIAL |->
		64'(bcnt_r + TW'(1)) * 64'(FEC_ACC_DEN) <=
		64'(pcfg_r) * 64'(MS_CYC) * 64'(FEC_ACC_NUM))
		else $error("Partial erase too long.");
	AST_CFG_RST: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> pcfg_r == FEC_PARTCFG_RST) else $error("Cfg reset wrong.");
	AST_FILL: assert property (@(posedge pclk) disable iff (!presetn)
		arr_start && cmd_r.op == FEC_OP_PAGE |-> arr_fill_ones && cmd_r.data == 32'hffffffff)
		else $error("Page erase not ones.");

	// Config area erase shares the page interval and the ones fill.
	AST_UCFG_T: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && cmd_r.op == FEC_OP_UCFG |-> bcnt_r < TW'(PAGE_CYC))
		else $error("Config erase too long.");
	AST_UCFG_FILL: assert property (@(posedge pclk) disable iff (!presetn)
		arr_start && cmd_r.op == FEC_OP_UCFG |-> arr_fill_ones && cmd_r.data == 32'hffffffff)
		else $error("Config erase not ones.");
	AST_ALL_FILL: assert property (@(posedge pclk) disable iff (!presetn)
		arr_start && cmd_r.op == FEC_OP_ALL |-> arr_fill_ones && cmd_r.addr == 32'h0)
		else $error("Full erase command wrong.");
	// A partial pulse must not claim the page is fully erased.
	AST_PART_NOFILL: assert property (@(posedge pclk) disable iff (!presetn)
		arr_start && cmd_r.op == FEC_OP_PARTIAL |-> !arr_fill_ones)
		else $error("Partial erase marked complete.");
	AST_START_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		arr_start |=> !arr_start) else $error("Start strobe longer than one cycle.");
	AST_BUSY_END: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && !running |=> !busy_r) else $error("Busy outlived its interval.");
	AST_RO_MODE: assert property (@(posedge pclk) disable iff (!presetn)
		start_nxt |-> mode_r != FEC_MODE_RO) else $error("Operation in read-only mode.");

endmodule
`default_nettype wire

/* tb/fec_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fec_ctrl_tb
	import fec_pkg::*;
;
	// Short intervals keep the run small.
	localparam int unsigned WC = 10;
	localparam int unsigned PC = 50;
	localparam int unsigned AC = 100;
	// Eight cycles per ms keep the shortest partial busy past the refused retrigger.
	localparam int unsigned MC = 8;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        arr_start;
	logic        arr_fill_ones;
	logic        busy;
	fec_cmd_t    arr_cmd;
	int          errors      = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	int          bcnt        = 0;
	logic [31:0] rd;
	logic        err;
	logic [31:0] cfg;
	logic [31:0] pa;

	fec_ctrl #(.WRITE_CYC(WC), .PAGE_CYC(PC), .ALL_CYC(AC), .MS_CYC(MC)) u_fec_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.arr_cmd(arr_cmd), .arr_start(arr_start), .arr_fill_ones(arr_fill_ones), .busy(busy));

	// Clock of 25 ns.
	always #12.5 pclk = ~pclk;

	// Busy cycle counter and run limit.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		// The start strobe opens a new interval count.
		if (arr_start === 1'b1) begin
			bcnt <= 1;
		end else if (busy === 1'b1) begin
			bcnt <= bcnt + 1;
		end
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_dur(input int n, input int lo, input int hi);
		checks_done++;
		if (n < lo || n > hi) begin
			errors++;
			$display("[ERR] %0t busy %0d cycles, want %0d..%0d", $time, n, lo, hi);
		end
	endtask

	// Busy length expected for each operation.
	function automatic int exp_cyc(input fec_op_t op);
		case (op)
			FEC_OP_WRITE: return WC;
			FEC_OP_ALL: return AC;
			FEC_OP_PARTIAL: return int'(cfg) * MC;
			default: return PC;
		endcase
	endfunction

	// One APB transfer; holds the request until pready is seen.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The first edge with pready high ends this wait, or else the bench timeout.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// A refused trigger must start nothing.
	task automatic idle(input logic [11:0] a);
		apb(1'b1, a, 32'h00001000);
		#1;
		chk({arr_start, busy}, 32'h0);
	endtask

	// A taken trigger: strobe, command, ready flag and interval length.
	task automatic trig(input logic [11:0] a, input logic [31:0] v, input fec_op_t op);
		int e;
		e = exp_cyc(op);
		apb(1'b1, a, v);
		#1;
		chk({arr_start, busy}, 32'h3);
		chk({29'h0, arr_cmd.op}, {29'h0, op});
		chk({31'h0, arr_fill_ones}, {31'h0, op inside {FEC_OP_PAGE, FEC_OP_ALL, FEC_OP_UCFG}});
		if (op inside {FEC_OP_PAGE, FEC_OP_PARTIAL, FEC_OP_WRITE}) begin
			chk(arr_cmd.addr, v);
		end
		apb(1'b0, FEC_OFF_READY, 32'h0);
		chk(rd, 32'h0);
		// A second trigger while busy must be dropped.
		apb(1'b1, FEC_OFF_ALL, 32'h0);
		while (busy === 1'b1) begin
			@(posedge pclk);
			#1;
		end
		#1;
		chk_dur(bcnt, e - 1, (op == FEC_OP_PARTIAL) ? e * FEC_ACC_NUM / FEC_ACC_DEN : e);
		chk({29'h0, arr_cmd.op}, {29'h0, op});
		apb(1'b0, FEC_OFF_READY, 32'h0);
		chk(rd, 32'h1);
	endtask

	// Main sequence.
	initial begin
		void'($urandom(5));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		cfg = FEC_PARTCFG_RST;
		apb(1'b0, FEC_OFF_PARTCFG, 32'h0);
		chk(rd, FEC_PARTCFG_RST);
		apb(1'b0, FEC_OFF_READY, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, FEC_OFF_CONFIG, 32'h0);
		chk(rd, {30'h0, FEC_MODE_RO});
		idle(FEC_OFF_PAGE);
		apb(1'b1, FEC_OFF_CONFIG, {30'h0, FEC_MODE_WEN});
		idle(FEC_OFF_ALL);
		pa = $urandom;
		// one random word is written once, before erase mode is set.
		apb(1'b1, FEC_OFF_WADDR, pa);
		trig(FEC_OFF_WRITE, {pa[31:2], 2'b00}, FEC_OP_WRITE);
		chk(arr_cmd.data, pa);
		apb(1'b1, FEC_OFF_CONFIG, {30'h0, FEC_MODE_EEN});
		// partials on the page follow full erases of it.
		for (int i = 0; i < 3; i++) begin
			pa = 32'($urandom_range(0, 63)) << 12;
			trig(FEC_OFF_PAGE, pa, FEC_OP_PAGE);
			trig(FEC_OFF_ALIAS0, pa, FEC_OP_PAGE);
			cfg = 32'($urandom_range(1, 6));
			apb(1'b1, FEC_OFF_PARTCFG, cfg);
			apb(1'b0, FEC_OFF_PARTCFG, 32'h0);
			chk(rd, cfg);
			trig(FEC_OFF_PARTIAL, pa, FEC_OP_PARTIAL);
		end
		trig(FEC_OFF_ALL, 32'h0, FEC_OP_ALL);
		trig(FEC_OFF_UCFG, 32'h0, FEC_OP_UCFG);
		apb(1'b1, FEC_OFF_PARTCFG, 32'h0);
		idle(FEC_OFF_PARTIAL);
		// Unmapped offset answers with an error.
		apb(1'b0, 12'h600, 32'h0);
		chk({31'h0, err}, 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
